// ---- stc_ctrl.sv ----
/*
 Two-cycle-per-column SRAM sequencer: row states, exception abort, column
 pipeline, wait states, turn-off states and an APB configuration slave.
 Assumes one clock, a synchronous reset, and a transfer engine that holds
 its request until req_ready.
*/
// The APB interface to the registers and the register addresses were left to the implementer.
// Contract
// - Read row access walks first address, second address, row lead, optional insert.
// - Read second address state holds while READY is low.
// - Enabled exception in second address state aborts through exception return.
// - Reads with exceptions get one insert, three cycles before first column.
// - Two column stages, a new column at most every two cycles.
// - Read first stage drives column address, column code, strobes from mid-cycle.
// - READY sampled each second stage; low repeats the stage.
// - Wait field repeats second stage once, twice or three times.
// - Read data captured at end of last second stage.
// - Column idle shows idle code with all strobes inactive.
// - A started column access always runs all its stages.
// - After last column go to turn-off and first address, or idle.
// - Reads add one turn-off state plus configured extra ones.
// - A bubble gives idle cycles until the next access is ready.
// - Write row access adds row-to-column state; READY low holds there too.
// - Writes with exceptions get inserts, five cycles before first column.
// - Write first stage drives column, code, data, valid strobes at start.
// - Write second stage keeps data, drops strobes at mid-cycle.
// - Writes add the automatic turn-off only for peripheral transfers.
// - Peripheral writes float data bus and keep transceiver enable high.
`timescale 1ns/1ps
`include "stc_defines.svh"

module stc_ctrl #(
   parameter int ADDR_W = 12
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // APB slave.
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Transfer engine side.
   input wire logic req_valid,
   input wire stc_pkg::stc_req_t req,
   output logic req_ready,
   output logic [63:0] rd_data,
   output logic rd_valid,
   // Memory pins.
   input wire logic ready_pin,
   input wire logic exception_pin,
   input wire logic [63:0] ad_in,
   output logic [63:0] ad_out,
   output logic ad_oe,
   output logic [16:0] multiplexed_row_column_address,
   output logic [1:0] status_code,
   output logic [7:0] byte_strobe_n,
   output logic transceiver_enable_out
);
   import stc_pkg::*;

   if (ADDR_W < 12) begin : g_addr_check
      $error("ADDR_W too small for the register map");
   end

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic ready_s1, ready_s2, exc_s1, exc_s2;
   logic [63:0] ad_s1, ad_s2;

   // READY, exception and bus pins pass two flops each.
   always_ff @(posedge clk) begin
      if (rst) begin
         ready_s1 <= 1'b0;
         ready_s2 <= 1'b0;
         exc_s1 <= 1'b0;
         exc_s2 <= 1'b0;
         ad_s1 <= 64'h0;
         ad_s2 <= 64'h0;
      end else begin
         ready_s1 <= ready_pin;
         ready_s2 <= ready_s1;
         exc_s1 <= exception_pin;
         exc_s2 <= exc_s1;
         ad_s1 <= ad_in;
         ad_s2 <= ad_s1;
      end
   end

   // ----------------------------------------------------------------------
   // Configuration register over APB
   // ----------------------------------------------------------------------
   stc_cfg_t cfg_r;
   stc_state_t state_r, state_nxt;
   logic wr_r, pdpt_r;
   logic apb_wr, map_hit;

   function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
      is_reg = (a[11:0] == ofs);
   endfunction

   assign map_hit = is_reg(paddr, `STC_CFG_OFS) || is_reg(paddr, `STC_STAT_OFS) ||
                    is_reg(paddr, `STC_RDLO_OFS) || is_reg(paddr, `STC_RDHI_OFS);
   assign apb_wr = psel && penable && pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !map_hit;

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_r <= `STC_CFG_RST;
      end else if (apb_wr && is_reg(paddr, `STC_CFG_OFS)) begin
         cfg_r <= {pwdata[`STC_TO_LSB +: 3], pwdata[`STC_EXC_BIT], pwdata[`STC_WS_LSB +: 2]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         case (paddr[11:0])
            `STC_CFG_OFS: prdata <= {25'h0, cfg_r.extra_to, 1'b0, cfg_r.exc_en, cfg_r.ws};
            `STC_STAT_OFS: prdata <= {26'h0, pdpt_r, wr_r, state_r};
            `STC_RDLO_OFS: prdata <= rd_data[31:0];
            `STC_RDHI_OFS: prdata <= rd_data[63:32];
            default: prdata <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   logic [2:0] cnt_r, cnt_nxt;
   logic [3:0] to_total;
   logic take;

   // Turn-off count, automatic one for reads and peripheral writes plus configured extra.
   assign to_total = {3'h0, (!wr_r || pdpt_r)} + {1'b0, cfg_r.extra_to};

   // Column follow-up or row change after the last column.
   function automatic stc_state_t after_col(input logic v, input logic nr,
                                            input logic [3:0] to);
      if (v && !nr) begin
         after_col = STC_C1;
      end else if (v && to != 4'h0) begin
         after_col = STC_RTO;
      end else if (v) begin
         after_col = STC_AD1;
      end else begin
         after_col = STC_CI;
      end
   endfunction

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      take = 1'b0;
      case (state_r)
         STC_AD1: begin
            if (req_valid) begin
               state_nxt = STC_AD2;
            end
         end
         STC_AD2: begin
            if (cfg_r.exc_en && exc_s2) begin
               state_nxt = STC_REX;
            end else if (ready_s2) begin
               state_nxt = STC_RL1;
            end
         end
         STC_REX: begin
            state_nxt = STC_AD1;
         end
         STC_RL1: begin
            if (wr_r) begin
               state_nxt = STC_RCL;
            end else if (cfg_r.exc_en) begin
               state_nxt = STC_EXI;
               cnt_nxt = `STC_RD_EXI - 3'h1;
            end else begin
               state_nxt = STC_C1;
               take = 1'b1;
            end
         end
         STC_RCL: begin
            if (ready_s2 && cfg_r.exc_en) begin
               state_nxt = STC_EXI;
               cnt_nxt = `STC_WR_EXI - 3'h1;
            end else if (ready_s2) begin
               state_nxt = STC_C1;
               take = 1'b1;
            end
         end
         STC_EXI: begin
            if (cnt_r == 3'h0) begin
               state_nxt = STC_C1;
               take = 1'b1;
            end else begin
               cnt_nxt = cnt_r - 3'h1;
            end
         end
         STC_C1: begin
            state_nxt = STC_C2;
            cnt_nxt = 3'h0;
         end
         STC_C2: begin
            // Repeat until waits done and READY high.
            if (ready_s2 && cnt_r == {1'b0, cfg_r.ws}) begin
               state_nxt = after_col(req_valid, req.new_row, to_total);
               take = (state_nxt == STC_C1);
               cnt_nxt = to_total[2:0] - 3'h1;
            end else if (cnt_r != {1'b0, cfg_r.ws}) begin
               cnt_nxt = cnt_r + 3'h1;
            end
         end
         STC_CI: begin
            state_nxt = after_col(req_valid, req.new_row, to_total);
            take = (state_nxt == STC_C1);
            cnt_nxt = to_total[2:0] - 3'h1;
         end
         STC_RTO: begin
            if (cnt_r == 3'h0) begin
               state_nxt = STC_AD1;
            end else begin
               cnt_nxt = cnt_r - 3'h1;
            end
         end
         default: begin
            state_nxt = STC_AD1;
         end
      endcase
   end

   assign req_ready = take;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= STC_AD1;
         cnt_r <= 3'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_r <= 1'b0;
         pdpt_r <= 1'b0;
      end else if (state_r == STC_AD1 && req_valid) begin
         wr_r <= req.write;
         pdpt_r <= req.pdpt;
      end
   end

   // ----------------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------------
   logic [7:0] be_r, pos_a_r, pos_b_r;
   logic neg_r, col_nxt;

   assign col_nxt = (state_nxt == STC_C1) || (state_nxt == STC_C2);

   // Address, code and data of the column.
   always_ff @(posedge clk) begin
      if (rst) begin
         multiplexed_row_column_address <= 17'h0;
         status_code <= `STC_ST_IDLE;
         ad_out <= 64'h0;
         be_r <= 8'h0;
         ad_oe <= 1'b0;
         transceiver_enable_out <= 1'b1;
      end else begin
         status_code <= (state_nxt == STC_C1) ? `STC_ST_COL : `STC_ST_IDLE;
         ad_oe <= col_nxt && wr_r && !pdpt_r;
         transceiver_enable_out <= !(col_nxt && !pdpt_r);
         if (state_r == STC_AD1 && req_valid) begin
            multiplexed_row_column_address <= req.row;
         end else if (take) begin
            multiplexed_row_column_address <= req.col;
            ad_out <= req.data;
            be_r <= req.be;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pos_a_r <= 8'h0;
         pos_b_r <= 8'h0;
      end else if (wr_r) begin
         pos_a_r <= (state_nxt == STC_C1) ? req.be : 8'h0;
         pos_b_r <= (state_nxt == STC_C2) ? be_r : 8'h0;
      end else begin
         pos_a_r <= (state_nxt == STC_C2) ? 8'hFF : 8'h0;
         pos_b_r <= (state_nxt == STC_C1) ? 8'hFF : 8'h0;
      end
   end

   // Half-cycle part, taken on the falling edge.
   always_ff @(negedge clk) begin
      if (rst) begin
         neg_r <= 1'b0;
      end else begin
         neg_r <= (state_r == STC_C1);
      end
   end

   assign byte_strobe_n = ~(pos_a_r | (pos_b_r & {8{neg_r}}));

   // ----------------------------------------------------------------------
   // Read data capture
   // ----------------------------------------------------------------------
   logic cap_d1, cap_d2;

   // Capture at end of last second stage, through the synchroniser.
   always_ff @(posedge clk) begin
      if (rst) begin
         cap_d1 <= 1'b0;
         cap_d2 <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 64'h0;
      end else begin
         cap_d1 <= (state_r == STC_C2) && (state_nxt != STC_C2) && !wr_r;
         cap_d2 <= cap_d1;
         rd_valid <= cap_d2;
         if (cap_d2) begin
            rd_data <= ad_s2;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_exc_abort: assert property (
      state_r == STC_AD2 && cfg_r.exc_en && exc_s2 |=>
      state_r == STC_REX ##1 state_r == STC_AD1)
      else $error("exception did not abort");
   a_row_wait: assert property (
      state_r == STC_AD2 && !exc_s2 && !ready_s2 |=> state_r == STC_AD2)
      else $error("row wait not held");
   a_rd_insert: assert property (
      state_r == STC_RL1 && !wr_r && cfg_r.exc_en |=>
      state_r == STC_EXI ##1 state_r == STC_C1)
      else $error("read insert wrong");
   a_wr_insert: assert property (
      state_r == STC_RCL && ready_s2 && cfg_r.exc_en |=>
      state_r == STC_EXI ##1 state_r == STC_EXI ##1 state_r == STC_C1)
      else $error("write inserts wrong");
   a_col_code: assert property (
      state_nxt == STC_C1 |=> status_code == `STC_ST_COL ##1 state_r == STC_C2)
      else $error("column stage code wrong");
   a_ready_stall: assert property (
      state_r == STC_C2 && !ready_s2 |=> state_r == STC_C2)
      else $error("READY low did not stall");
   a_ws_two: assert property (
      state_r == STC_C1 && cfg_r.ws == 2'h2 |=> (state_r == STC_C2) [*3])
      else $error("wait field two not honoured");
   a_ws_zero: assert property (
      state_r == STC_C1 && cfg_r.ws == 2'h0 ##1 ready_s2 |=> state_r != STC_C2)
      else $error("extra wait with field zero");
   a_rd_capture: assert property (
      state_r == STC_C2 && state_nxt != STC_C2 && !wr_r |-> ##3 rd_valid)
      else $error("read data not captured");
   a_idle_quiet: assert property (
      state_r == STC_CI |-> status_code == `STC_ST_IDLE && byte_strobe_n == 8'hFF)
      else $error("idle stage not quiet");
   a_rd_turnoff: assert property (
      state_r == STC_CI && !wr_r && req_valid && req.new_row |=> state_r == STC_RTO)
      else $error("read turn-off missing");
   a_pdpt_float: assert property (
      state_r == STC_C1 && wr_r && pdpt_r |-> !ad_oe && transceiver_enable_out)
      else $error("peripheral write drove bus");

   c_abort: cover property (state_r == STC_REX);
   c_ws_three: cover property (state_r == STC_C1 && cfg_r.ws == 2'h3 ##4 state_r == STC_C2);
   c_pdpt_wr: cover property (state_r == STC_C2 && wr_r && pdpt_r);
   c_bubble: cover property (state_r == STC_C2 ##1 state_r == STC_CI ##1 state_r == STC_C1);

endmodule

// ---- stc_defines.svh ----
/*
 Holds the register offsets, field positions, reset values, status codes
 and fixed cycle counts of the two-cycle SRAM column sequencer.
 Assumes it is included once per compilation unit by its bare name.
*/
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define STC_CFG_OFS 12'h000
`define STC_STAT_OFS 12'h004
`define STC_RDLO_OFS 12'h008
`define STC_RDHI_OFS 12'h00C

// ----------------------------------------------------------------------
// Configuration fields and reset value
// ----------------------------------------------------------------------
`define STC_WS_LSB 0
`define STC_EXC_BIT 2
`define STC_TO_LSB 4
`define STC_CFG_RST 6'h00

// ----------------------------------------------------------------------
// Status codes and cycle counts
// ----------------------------------------------------------------------
`define STC_ST_IDLE 2'h0
`define STC_ST_COL 2'h1
`define STC_RD_EXI 3'h1
`define STC_WR_EXI 3'h2

`endif

// ---- stc_pkg.sv ----
/*
 Holds the state, request and configuration types of the sequencer.
 Assumes nothing of its surroundings.
*/
package stc_pkg;

   typedef enum logic [3:0] {
      STC_AD1 = 4'h0,
      STC_AD2 = 4'h1,
      STC_RL1 = 4'h3,
      STC_EXI = 4'h2,
      STC_RCL = 4'h6,
      STC_C1 = 4'h7,
      STC_C2 = 4'h5,
      STC_CI = 4'h4,
      STC_RTO = 4'hC,
      STC_REX = 4'hD
   } stc_state_t;

   typedef struct packed {
      logic new_row;
      logic write;
      logic pdpt;
      logic [16:0] row;
      logic [16:0] col;
      logic [63:0] data;
      logic [7:0] be;
   } stc_req_t;

   typedef struct packed {
      logic [2:0] extra_to;
      logic exc_en;
      logic [1:0] ws;
   } stc_cfg_t;

endpackage

// ---- stc_mem_model.sv ----
/*
 Behavioural asynchronous SRAM with system ready logic on the memory pins.
 Assumes registered sequencer outputs and a single rising-edge clock.
*/
`timescale 1ns/1ps
`include "stc_defines.svh"

module stc_mem_model (
   // Clock and ready mode.
   input wire logic clk,
   input wire logic slow,
   // Memory pins.
   input wire logic [16:0] multiplexed_row_column_address,
   input wire logic [1:0] status_code,
   input wire logic [7:0] byte_strobe_n,
   input wire logic [63:0] ad_out,
   input wire logic ad_oe,
   output logic ready_pin,
   output logic [63:0] ad_in
);
   logic [63:0] mem [16];
   logic [3:0] col;
   logic [7:0] strb_q;
   logic oe_q;
   logic [63:0] dat_q;
   integer seed = 97;

   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = {8{i[7:0]}} ^ 64'h0123456789ABCDEF;
      end
      ready_pin = 1'b1;
      ad_in = 64'h0;
      col = 4'h0;
      strb_q = 8'hFF;
      oe_q = 1'b0;
      dat_q = 64'h0;
   end

   // ------------------------------------------------------------------
   // Array access
   // ------------------------------------------------------------------
   always @(posedge clk) begin
      if (status_code == `STC_ST_COL) begin
         col = multiplexed_row_column_address[3:0];
      end
      // Output drives only while strobes are low, otherwise it wanders.
      if (byte_strobe_n != 8'hFF && !ad_oe) begin
         ad_in <= mem[col];
      end else begin
         ad_in <= ~ad_in;
      end
      // Each lane is latched as its strobe goes inactive, if ad_oe was high while the strobe was active.
      for (int b = 0; b < 8; b++) begin
         if (!strb_q[b] && byte_strobe_n[b] && oe_q) begin
            mem[col][b*8 +: 8] = dat_q[b*8 +: 8];
         end
      end
      strb_q = byte_strobe_n;
      oe_q = ad_oe;
      dat_q = ad_out;
   end

   // ------------------------------------------------------------------
   // Ready logic
   // ------------------------------------------------------------------
   // Ready drops at random and comes back high.
   always @(posedge clk) begin
      ready_pin <= slow ? 1'($random(seed)) : 1'b1;
   end
endmodule

// ---- test_sram_two_cycle_column_access.sv ----
/*
 Self-checking bench for the two-cycle column sequencer with APB set-up.
 Assumes stc_pkg, stc_ctrl and stc_mem_model are compiled before it.
*/
`timescale 1ns/1ps
`include "stc_defines.svh"

module test_sram_two_cycle_column_access;
   import stc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, req_ready, rd_valid, ad_oe, txen, ready_pin;
   logic slow = 1'b0;
   logic req_valid = 1'b0;
   logic exception_pin = 1'b0;
   stc_req_t req = '0;
   logic [63:0] rd_data, ad_out, ad_in, last_rd;
   logic [16:0] mrca;
   logic [1:0] status_code;
   logic [7:0] byte_strobe_n;
   logic [63:0] shadow [16];
   logic [63:0] exp_q [$];
   int fails = 0;
   int cmp_count = 0;
   integer seed = 97;

   always #5 clk = ~clk;

   stc_ctrl #(.ADDR_W(12)) dut_u (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .ready_pin(ready_pin), .exception_pin(exception_pin), .ad_in(ad_in),
      .ad_out(ad_out), .ad_oe(ad_oe), .multiplexed_row_column_address(mrca),
      .status_code(status_code), .byte_strobe_n(byte_strobe_n),
      .transceiver_enable_out(txen));

   stc_mem_model mem_u (.clk(clk), .slow(slow), .multiplexed_row_column_address(mrca),
      .status_code(status_code), .byte_strobe_n(byte_strobe_n), .ad_out(ad_out),
      .ad_oe(ad_oe), .ready_pin(ready_pin), .ad_in(ad_in));

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      cmp_count++;
      if (seen !== want) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic end_of_test();
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      input logic [31:0] want, input logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
      end
      check({63'h0, pslverr}, {63'h0, err});
      if (!wr) begin
         check({32'h0, prdata}, {32'h0, want});
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic col_req(input logic nr, input logic wr, input logic pd,
                          input logic [3:0] c, input logic [7:0] lanes);
      int n;
      logic [63:0] d;
      n = 0;
      d = {$random(seed), $random(seed)};
      for (int b = 0; b < 8; b++) begin
         if (wr && !pd && lanes[b]) begin
            shadow[c][b*8 +: 8] = d[b*8 +: 8];
         end
      end
      if (!wr) begin
         exp_q.push_back(shadow[c]);
         last_rd = shadow[c];
      end
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{new_row: nr, write: wr, pdpt: pd, row: 17'($random(seed)),
               col: {13'h0, c}, data: d, be: lanes};
      do begin
         @(negedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 200);
      if (n >= 200) begin
         fails++;
      end
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      #1;
      check({62'h0, status_code}, {62'h0, `STC_ST_COL});
      check({47'h0, mrca}, {47'h0, 13'h0, c});
      check({56'h0, byte_strobe_n}, {56'h0, wr ? ~lanes : 8'h00});
      check({62'h0, ad_oe, txen}, {62'h0, wr & ~pd, pd});
   endtask

   // ------------------------------------------------------------------
   // Read data monitor
   // ------------------------------------------------------------------
   always @(negedge clk) begin
      if (rd_valid === 1'b1) begin
         check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data);
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      logic [31:0] cfg;
      logic [3:0] c;
      for (int i = 0; i < 16; i++) begin
         shadow[i] = {8{i[7:0]}} ^ 64'h0123456789ABCDEF;
      end
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, `STC_CFG_OFS, 32'h0, 32'h0, 1'b0);
      apb(1'b1, 12'h010, 32'hFFFFFFFF, 32'h0, 1'b1);
      apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
      // Every wait field, exceptions and slow ready in turn.
      for (int k = 0; k < 16; k++) begin
         cfg = {25'h0, k[3] ? 3'h5 : 3'h0, 1'b0, k[2], k[1:0]};
         slow <= k[0] ^ k[3];
         apb(1'b1, `STC_CFG_OFS, cfg, 32'h0, 1'b0);
         apb(1'b0, `STC_CFG_OFS, 32'h0, cfg, 1'b0);
         c = 4'($random(seed));
         // Exception pulse aborts the first row attempt when no extra turn-off states are set (k[3] low).
         exception_pin <= k[2];
         fork
            begin
               repeat (4) @(posedge clk);
               exception_pin <= 1'b0;
            end
         join_none
         col_req(1'b1, 1'b1, 1'b0, c, 8'($random(seed)) | 8'h01);
         col_req(1'b0, 1'b1, 1'b0, c + 4'h1, 8'($random(seed)) | 8'h80);
         // New row read of what was written.
         col_req(1'b1, 1'b0, 1'b0, c, 8'h00);
         col_req(1'b0, 1'b0, 1'b0, c + 4'h1, 8'h00);
         // Bubble if the second stage ends within three clocks, then same-row restart.
         repeat (3) @(posedge clk);
         col_req(1'b0, 1'b0, 1'b0, c + 4'h2, 8'h00);
         col_req(1'b1, 1'b1, 1'b1, c + 4'h3, 8'hFF);
         col_req(1'b1, 1'b0, 1'b0, c + 4'h3, 8'h00);
         repeat (40) @(posedge clk);
         @(negedge clk);
         #1;
         check({54'h0, status_code, byte_strobe_n}, {54'h0, `STC_ST_IDLE, 8'hFF});
         check({63'h0, ad_oe}, 64'h0);
         apb(1'b0, `STC_RDLO_OFS, 32'h0, last_rd[31:0], 1'b0);
         apb(1'b0, `STC_RDHI_OFS, 32'h0, last_rd[63:32], 1'b0);
      end
      check(64'(exp_q.size()), 64'h0);
      end_of_test();
   end

   initial begin
      #300000;
      fails++;
      end_of_test();
   end
endmodule
